// ### hdl/vep_edge_pad.v
// edge padding engine with run control, debug suspend and power handshake
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - copy outermost picture pixels outward by the pad width on all four sides
// - field mode fills vertical pad lines of each field from that same field
// - left pad repeats leftmost pixels, right pad repeats rightmost, per field
// - frame mode fills top pads from top field line 0, bottom from last bottom line
// - there is no software reset, only the hardware reset
// - bad configuration takes trigger but engine never returns to ready
// - one done interrupt pulse when the configured processing finishes
// - power controller may change state only while the engine is ready
// - free debug mode ignores the suspend input entirely
// - configuration registers stay accessible whatever the suspend input
// - soft stop halts only after the current processing unit completes
// - run trigger ignores writes during suspend; a new run needs a new trigger
// - completion in suspend pulses now, or defers pulse and trigger clear
// - debug mode resets to soft stop
// - programmed addresses mark the area start, one scale for all layouts
// - luma and chroma pad widths sit in two registers at 184h and 188h
`include "vep_regs.vh"

module vep_edge_pad (
  input  wire                  clk,
  input  wire                  rst_n,
  input  wire [`VEP_AW-1:0]    reg_addr,
  input  wire [31:0]           reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [31:0]           reg_rdata,
  output reg                   mem_req,
  output reg                   mem_we,
  output reg  [23:0]           mem_addr,
  output reg  [7:0]            mem_wdata,
  input  wire                  mem_ack,
  input  wire [7:0]            mem_rdata,
  input  wire                  debug_suspend,
  input  wire                  pwr_req,
  output wire                  pwr_ack,
  output reg                   conversion_done_irq
);

  // configuration
  reg  [31:0]        ctrl_q;
  reg                run_q;
  reg  [2:0]         dbg_q;
  reg  [15:0]        req_q;
  reg  [15:0]        proc_q;
  reg  [23:0]        base_q [0:3];
  reg  [15:0]        off_q  [0:3];
  reg  [11:0]        wid_q  [0:1];
  reg  [11:0]        hgt_q  [0:1];
  reg  [7:0]         pad_q  [0:1];

  // engine state
  reg  [2:0]         st_q;
  reg  [1:0]         pass_q;
  reg  signed [13:0] x_q;
  reg  signed [13:0] y_q;
  reg  [15:0]        unit_q;
  reg                pend_q;
  reg  [2:0]         sus_q;
  reg                sus_s_q;

  wire sus_eff = sus_s_q & (dbg_q[1:0] != `VEP_DBG_FREE);
  wire ilace   = ctrl_q[`VEP_B_ILACE];

  // suspend arrives from another domain: change counts once stages 2 and 3 agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sus_q   <= 3'h0;
      sus_s_q <= 1'b0;
    end else begin
      sus_q <= {sus_q[1:0], debug_suspend};
      if (sus_q[1] == sus_q[2])
        sus_s_q <= sus_q[2];
    end
  end

  // pass p = {chroma, bottom}; progressive sources use the top set only
  // a progressive picture is one set of lines, so its field enables are ignored
  reg  [3:0] pass_en;
  integer    i;
  always @* begin
    pass_en = 4'h0;
    for (i = 0; i < 4; i = i + 1)
      pass_en[i] = (i > 1 ? ctrl_q[`VEP_B_CHROMA] : ctrl_q[`VEP_B_LUMA]) &
                   (ilace ? (i % 2 == 1 ? ctrl_q[`VEP_B_BOT] : ctrl_q[`VEP_B_TOP])
                          : (i % 2 == 0));
  end

  // own loop index, so no variable is written by two processes
  reg  [2:0] nxt;
  reg  [2:0] frst;
  integer    j;
  always @* begin
    nxt  = 3'h4;
    frst = 3'h4;
    for (j = 3; j >= 0; j = j - 1) begin
      if (pass_en[j] && j > pass_q)
        nxt = j[2:0];
      if (pass_en[j])
        frst = j[2:0];
    end
  end

  // start check: trigger is still taken if this fails
  wire cfg_ok = (ctrl_q[`VEP_B_LUMA] | ctrl_q[`VEP_B_CHROMA]) &
                (~ilace | ctrl_q[`VEP_B_TOP] | ctrl_q[`VEP_B_BOT]) &
                (req_q != 16'h0) & (proc_q != 16'h0);

  wire               pl  = pass_q[1];
  wire signed [13:0] w   = {6'h0, pad_q[pl]};
  wire signed [13:0] wd  = {2'h0, wid_q[pl]};
  wire signed [13:0] ht  = {2'h0, hgt_q[pl]};
  wire               in_row = (y_q >= 14'sd0) && (y_q < ht);
  wire               row_end = (x_q == wd + w - 14'sd1);
  wire               pass_end = row_end && (y_q == ht + w - 14'sd1);
  wire               unit_end = row_end && (unit_q == proc_q - 16'h1);

  // source pixel: clamp column, clamp row, pick field by pad mode
  wire               frm = ilace & ~ctrl_q[`VEP_B_FLDPAD];
  wire signed [13:0] sx = (x_q < 14'sd0) ? 14'sd0 :
                          (x_q >= wd) ? wd - 14'sd1 : x_q;
  wire signed [13:0] sy = (y_q < 14'sd0) ? 14'sd0 :
                          (y_q >= ht) ? ht - 14'sd1 : y_q;
  wire [1:0] sf = (!frm || in_row) ? pass_q :
                  {pl, (y_q >= ht)};

  // result base address is the start of the stored area, same scale everywhere
  // factors widened to the product width first, so no bit is padded silently
  wire signed [30:0] sy_x   = {{17{sy[13]}}, sy};
  wire signed [30:0] y_x    = {{17{y_q[13]}}, y_q};
  wire signed [30:0] s_prod = sy_x * $signed({15'h0, off_q[sf]});
  wire signed [30:0] d_prod = y_x * $signed({15'h0, off_q[pass_q]});
  wire signed [31:0] s_sum  = $signed({8'h0, base_q[sf]}) + $signed({s_prod[30], s_prod}) +
                              $signed({{18{sx[13]}}, sx});
  wire signed [31:0] d_sum  = $signed({8'h0, base_q[pass_q]}) + $signed({d_prod[30], d_prod}) +
                              $signed({{18{x_q[13]}}, x_q});

  assign pwr_ack = pwr_req & (st_q == `VEP_ST_IDLE);

  wire done_now = (st_q == `VEP_ST_STEP) && pass_end && (nxt == 3'h4);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q                <= `VEP_ST_IDLE;
      pass_q              <= 2'h0;
      x_q                 <= 14'sd0;
      y_q                 <= 14'sd0;
      unit_q              <= 16'h0;
      pend_q              <= 1'b0;
      run_q               <= 1'b0;
      mem_req             <= 1'b0;
      mem_we              <= 1'b0;
      mem_addr            <= 24'h0;
      mem_wdata           <= 8'h0;
      conversion_done_irq <= 1'b0;
    end else begin
      conversion_done_irq <= 1'b0;
      // deferred completion is released when suspend drops
      if (pend_q && !sus_eff) begin
        pend_q              <= 1'b0;
        run_q               <= 1'b0;
        conversion_done_irq <= 1'b1;
      end
      // run bit stays set while deferred, so no new trigger can slip in
      if (done_now) begin
        if (sus_eff && dbg_q[`VEP_B_DEFER]) begin
          pend_q <= 1'b1;
        end else begin
          run_q               <= 1'b0;
          conversion_done_irq <= 1'b1;
        end
      end
      // trigger write: ignored in suspend, set wins over a same-cycle clear
      if (reg_wr && reg_addr == `VEP_CTRL && reg_wdata[`VEP_B_RUN] &&
          !sus_eff && st_q == `VEP_ST_IDLE && !run_q)
        run_q <= 1'b1;
      case (st_q)
        `VEP_ST_IDLE: begin
          if (run_q && !pend_q) begin
            if (!cfg_ok)
              st_q <= `VEP_ST_STUCK;
            else begin
              pass_q <= frst[1:0];
              st_q   <= `VEP_ST_PASS;
            end
          end
        end
        `VEP_ST_PASS: begin
          x_q    <= -w;
          y_q    <= -w;
          unit_q <= 16'h0;
          if (w == 14'sd0 || wd == 14'sd0 || ht == 14'sd0) begin
            if (nxt == 3'h4) begin
              st_q                <= `VEP_ST_IDLE;
              run_q               <= 1'b0;
              conversion_done_irq <= 1'b1;
            end else
              pass_q <= nxt[1:0];
          end else
            st_q <= `VEP_ST_RD;
        end
        `VEP_ST_RD: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= s_sum[23:0];
          end else if (mem_ack) begin
            mem_we    <= 1'b1;
            mem_addr  <= d_sum[23:0];
            mem_wdata <= mem_rdata;
            st_q      <= `VEP_ST_WR;
          end
        end
        `VEP_ST_WR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            st_q    <= `VEP_ST_STEP;
          end
        end
        `VEP_ST_STEP: begin
          st_q <= `VEP_ST_RD;
          if (in_row && x_q == -14'sd1)
            x_q <= wd;
          else if (!row_end)
            x_q <= x_q + 14'sd1;
          else begin
            x_q    <= -w;
            y_q    <= y_q + 14'sd1;
            unit_q <= unit_end ? 16'h0 : unit_q + 16'h1;
            if (pass_end) begin
              if (nxt == 3'h4)
                st_q <= `VEP_ST_IDLE;
              else begin
                pass_q <= nxt[1:0];
                st_q   <= `VEP_ST_PASS;
              end
            end else if (unit_end && sus_eff)
              st_q <= `VEP_ST_HALT;
          end
        end
        `VEP_ST_HALT: begin
          if (!sus_eff)
            st_q <= `VEP_ST_RD;
        end
        `VEP_ST_STUCK: begin
          // only rst_n leaves here; the power handshake stays refused meanwhile
          st_q <= `VEP_ST_STUCK;
        end
        default: st_q <= `VEP_ST_IDLE;
      endcase
    end
  end

  // register writes are honoured whatever the suspend input
  integer f;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 32'h0;
      dbg_q  <= `VEP_DBG_RST;
      req_q  <= 16'h0;
      proc_q <= 16'h0;
      for (f = 0; f < 4; f = f + 1) begin
        base_q[f] <= 24'h0;
        off_q[f]  <= 16'h0;
      end
      for (f = 0; f < 2; f = f + 1) begin
        wid_q[f] <= 12'h0;
        hgt_q[f] <= 12'h0;
        pad_q[f] <= 8'h0;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `VEP_CTRL:  ctrl_q <= {25'h0, reg_wdata[6:1], 1'b0};
        `VEP_DBG:   dbg_q  <= reg_wdata[2:0];
        `VEP_REQ:   req_q  <= reg_wdata[15:0];
        `VEP_PROC:  proc_q <= reg_wdata[15:0];
        `VEP_LSIZE: begin
          wid_q[0] <= reg_wdata[11:0];
          hgt_q[0] <= reg_wdata[27:16];
        end
        `VEP_CSIZE: begin
          wid_q[1] <= reg_wdata[11:0];
          hgt_q[1] <= reg_wdata[27:16];
        end
        `VEP_LPAD:  pad_q[0] <= reg_wdata[7:0];
        `VEP_CPAD:  pad_q[1] <= reg_wdata[7:0];
        default: begin
          for (f = 0; f < 4; f = f + 1) begin
            if (reg_addr == `VEP_FBASE0 + f[8:0] * `VEP_FSTEP)
              base_q[f] <= reg_wdata[23:0];
            if (reg_addr == `VEP_FBASE0 + f[8:0] * `VEP_FSTEP + `VEP_FOFF)
              off_q[f] <= reg_wdata[15:0];
          end
        end
      endcase
    end
  end

  // read data stand in the cycle after the strobe; unmapped reads give zero
  reg [31:0] rd_d;
  integer    g;
  always @* begin
    rd_d = 32'h0;
    case (reg_addr)
      `VEP_CTRL:  rd_d = ctrl_q | {23'h0, (st_q != `VEP_ST_IDLE), 7'h0, run_q};
      `VEP_DBG:   rd_d = {29'h0, dbg_q};
      `VEP_REQ:   rd_d = {16'h0, req_q};
      `VEP_PROC:  rd_d = {16'h0, proc_q};
      `VEP_LSIZE: rd_d = {4'h0, hgt_q[0], 4'h0, wid_q[0]};
      `VEP_CSIZE: rd_d = {4'h0, hgt_q[1], 4'h0, wid_q[1]};
      `VEP_LPAD:  rd_d = {24'h0, pad_q[0]};
      `VEP_CPAD:  rd_d = {24'h0, pad_q[1]};
      default: begin
        for (g = 0; g < 4; g = g + 1) begin
          if (reg_addr == `VEP_FBASE0 + g[8:0] * `VEP_FSTEP)
            rd_d = {8'h0, base_q[g]};
          if (reg_addr == `VEP_FBASE0 + g[8:0] * `VEP_FSTEP + `VEP_FOFF)
            rd_d = {16'h0, off_q[g]};
        end
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rd_d;
    else
      reg_rdata <= 32'h0;
  end

endmodule

// ### hdl/vep_regs.vh
// register offsets, fields, reset values and encodings of the edge pad engine
`ifndef VEP_REGS_VH
`define VEP_REGS_VH

`define VEP_AW              9
`define VEP_CTRL            9'h004
`define VEP_DBG             9'h01c
`define VEP_REQ             9'h024
`define VEP_PROC            9'h028
`define VEP_FBASE0          9'h080
`define VEP_FSTEP           9'h00c
`define VEP_FOFF            9'h008
`define VEP_LSIZE           9'h0e4
`define VEP_CSIZE           9'h0ec
`define VEP_LPAD            9'h184
`define VEP_CPAD            9'h188

`define VEP_B_RUN           0
`define VEP_B_LUMA          1
`define VEP_B_CHROMA        2
`define VEP_B_TOP           3
`define VEP_B_BOT           4
`define VEP_B_ILACE         5
`define VEP_B_FLDPAD        6
`define VEP_B_STATE         8

`define VEP_B_DEFER         2
`define VEP_DBG_FREE        2'h0
`define VEP_DBG_SOFT        2'h1
`define VEP_DBG_HARD        2'h2
`define VEP_DBG_RST         3'h1

`define VEP_ST_IDLE         3'h0
`define VEP_ST_PASS         3'h1
`define VEP_ST_RD           3'h2
`define VEP_ST_WR           3'h3
`define VEP_ST_STEP         3'h4
`define VEP_ST_HALT         3'h5
`define VEP_ST_STUCK        3'h6

`endif

// ### verif/test_vep_edge_pad.sv
// self-checking bench for the edge pad engine
`timescale 1ns/1ps
`include "vep_regs.vh"
module test_vep_edge_pad;
  localparam int W = 2, WD = 2, H = 2;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, susp = 0, pwr_req = 1;
  logic [8:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic        mem_req, mem_we, mem_ack, pwr_ack, irq;
  logic [23:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  logic [3:0]  lat = 0;
  int          fail_count = 0, tests_run = 0, cyc = 0, irqs = 0, n0;
  always #25 clk = ~clk;
  vep_edge_pad u_vep_edge_pad (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .debug_suspend(susp),
    .pwr_req(pwr_req), .pwr_ack(pwr_ack), .conversion_done_irq(irq));
  vep_mem_model u_vep_mem_model (.clk(clk), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    // whole run needs a few thousand cycles
    if (cyc > 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  function automatic logic [7:0] pix(input int a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic int clip(input int v, input int hi);
    return v < 0 ? 0 : (v > hi ? hi : v);
  endfunction
  // one padding run, optional soft stop in mid-run, then every pad byte checked
  task automatic run(input int il, input int fld, input int stop);
    int q, s, d, n1;
    logic [31:0] cfg;
    cfg = 32'h1a | (il << 5) | (fld << 6);
    u_vep_mem_model.wmem.delete();
    n0 = irqs;
    wr(`VEP_CTRL, cfg | 1);
    if (stop) begin
      repeat (10) @(posedge clk);
      susp <= 1'b1;
      repeat (120) @(posedge clk);
      n1 = u_vep_mem_model.wmem.num();
      repeat (60) @(posedge clk);
      chk(u_vep_mem_model.wmem.num(), n1);
      chk(irqs - n0, 0);
      susp <= 1'b0;
    end
    for (int i = 0; i < 5000 && irqs == n0; i++) @(posedge clk);
    @(posedge clk);
    chk(irqs - n0, 1);
    rc(`VEP_CTRL, cfg);
    chk(u_vep_mem_model.wmem.num(),
        (il + 1) * ((H + 2 * W) * (WD + 2 * W) - H * WD));
    for (int p = 0; p <= il; p++)
      for (int y = -W; y < H + W; y++)
        for (int x = -W; x < WD + W; x++) begin
          d = 32'h1000 * (p + 1) + y * 16 + x;
          q = (il && !fld) ? (y < 0 ? 0 : (y >= H ? 1 : p)) : p;
          s = 32'h1000 * (q + 1) + clip(y, H - 1) * 16 + clip(x, WD - 1);
          if (y >= 0 && y < H && x >= 0 && x < WD)
            chk(u_vep_mem_model.wmem.exists(d), 0);
          else chk(u_vep_mem_model.wmem[d], pix(s));
        end
    $display("run il=%0d fld=%0d stop=%0d done", il, fld, stop);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rc(`VEP_DBG, 32'h1);
    rc(`VEP_CTRL, 32'h0);
    rc(9'h1f0, 32'h0);
    wr(`VEP_CPAD, 32'ha4);
    rc(`VEP_CPAD, 32'ha4);
    wr(`VEP_LPAD, W);
    rc(`VEP_LPAD, W);
    #1 chk(pwr_ack, 1'b1);
    @(posedge clk);
    pwr_req <= 1'b0;
    @(posedge clk);
    #1 chk(pwr_ack, 1'b0);
    @(posedge clk);
    pwr_req <= 1'b1;
    wr(`VEP_REQ, 32'h1);
    wr(`VEP_PROC, 32'h1);
    wr(`VEP_LSIZE, (H << 16) | WD);
    wr(`VEP_FBASE0, 32'h1000);
    wr(`VEP_FBASE0 + `VEP_FOFF, 32'd16);
    wr(`VEP_FBASE0 + `VEP_FSTEP, 32'h2000);
    wr(`VEP_FBASE0 + `VEP_FSTEP + `VEP_FOFF, 32'd16);
    run(0, 0, 0);
    lat <= 4'h3;
    run(1, 0, 0);
    run(1, 1, 1);
    $display("padding tests done");
    // units longer than the picture: the run ends inside suspend, no halt
    wr(`VEP_PROC, 32'h40);
    for (int df = 0; df < 2; df++) begin
      wr(`VEP_DBG, 32'h1 | (df << 2));
      n0 = irqs;
      wr(`VEP_CTRL, 32'h1b);
      susp <= 1'b1;
      repeat (600) @(posedge clk);
      rc(`VEP_CTRL, 32'h1a | df);
      chk(irqs - n0, 1 - df);
      susp <= 1'b0;
      repeat (10) @(posedge clk);
      chk(irqs - n0, 1);
      rc(`VEP_CTRL, 32'h1a);
    end
    $display("suspend completion tests done");
    wr(`VEP_DBG, `VEP_DBG_FREE);
    susp <= 1'b1;
    run(1, 1, 0);
    wr(`VEP_DBG, `VEP_DBG_SOFT);
    repeat (6) @(posedge clk);
    wr(`VEP_CTRL, 32'h1b);
    rc(`VEP_CTRL, 32'h1a);
    susp <= 1'b0;
    repeat (6) @(posedge clk);
    n0 = irqs;
    wr(`VEP_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    rc(`VEP_CTRL, 32'h101);
    chk(pwr_ack, 1'b0);
    chk(irqs - n0, 0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(`VEP_CTRL, 32'h0);
    #1 chk(pwr_ack, 1'b1);
    $display("control tests done");
    conclude();
  end
endmodule

// ### verif/vep_edge_pad_chk.sv
// port assertions for the edge pad engine
`timescale 1ns/1ps
module vep_edge_pad_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic        pwr_req,
  input wire logic        pwr_ack,
  input wire logic        conversion_done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pwr_idle_only: assert property (pwr_ack |-> pwr_req && !mem_req)
    else $error("power ack while busy");
  a_irq_one_cycle: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("done pulse too long");
  a_irq_ready: assert property (conversion_done_irq |-> !mem_req && pwr_ack == pwr_req)
    else $error("done while not ready");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_req_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request dropped or changed");
  a_copy_pixel: assert property (mem_req && !mem_we && mem_ack |=>
    mem_req && mem_we && mem_wdata == $past(mem_rdata))
    else $error("written pixel differs from read");
  a_write_ends: assert property (mem_req && mem_we && mem_ack |=> !mem_req)
    else $error("request after write ack");
  a_read_first: assert property ($rose(mem_req) |-> !mem_we)
    else $error("access began with a write");
  c_done: cover property (conversion_done_irq);
  c_write: cover property (mem_req && mem_we && mem_ack);
  c_pwr: cover property (pwr_ack);
endmodule
bind vep_edge_pad vep_edge_pad_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pwr_req(pwr_req),
  .pwr_ack(pwr_ack), .conversion_done_irq(conversion_done_irq));

// ### verif/vep_mem_model.sv
// sdram stand-in: answers after lat cycles, keeps every pad write
`timescale 1ns/1ps
module vep_mem_model (
  input  wire logic        clk,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  logic [7:0] wmem [int];
  int         cnt = 0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 8'h00;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    // bus toggles when idle so stale data never looks valid
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      cnt <= cnt + 1;
      if (cnt >= lat) begin
        cnt <= 0;
        mem_ack <= 1'b1;
        if (mem_we) wmem[mem_addr] = mem_wdata;
        else mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;
      end
    end
  end
endmodule
